// ===== hdl/ldc_cfg_if.sv
// Purpose: Carries decoded converter settings between the top and its helpers.
// Assumes: Single clock domain.
// Notes:   Producer is the top, consumers are the pin and steering modules.
`timescale 1ns/1ps
interface ldc_cfg_if;
  import ldc_pkg::*;
  logic                  enable;
  logic                  pinAOn;
  logic                  pinBOn;
  ldc_hi_src_t           highSrc;
  logic                  lowSrc;
  logic [LDC_CODE_W-1:0] levelCode;
  ldc_gain_t             gain;
  modport producer (output enable, pinAOn, pinBOn, highSrc, lowSrc, levelCode, gain);
  modport consumer (input  enable, pinAOn, pinBOn, highSrc, lowSrc, levelCode, gain);
endinterface

// ===== hdl/ldc_pin_override.sv
// Purpose: Overrides the digital functions of the two ladder output pins.
// Assumes: Digital pin inputs arrive already synchronised.
// Notes:   Pure combinational gating.
`timescale 1ns/1ps
module ldc_pin_override
  import ldc_pkg::*;
(
  // Settings
  ldc_cfg_if.consumer cfg,
  // Port logic requests per pin, index 0 is pin a
  input  wire logic [1:0] portDriveEn,
  input  wire logic [1:0] portPullUpEn,
  input  wire logic [1:0] pinLevelSync,
  // Gated results
  output logic      [1:0] padDriveEn,
  output logic      [1:0] padPullUpEn,
  output logic      [1:0] padInputEn,
  output logic      [1:0] pinReadData,
  output logic      [1:0] padAnalogConnect
);
  logic [1:0] analogSel;

  assign analogSel = {cfg.pinBOn, cfg.pinAOn};

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : gPin
      assign padDriveEn[i]       = portDriveEn[i] & ~analogSel[i];
      assign padPullUpEn[i]      = portPullUpEn[i] & ~analogSel[i];
      assign padInputEn[i]       = ~analogSel[i];
      assign pinReadData[i]      = pinLevelSync[i] & ~analogSel[i];
      // The pin carries the voltage only while the ladder itself is on.
      assign padAnalogConnect[i] = analogSel[i] & cfg.enable;
    end
  endgenerate
endmodule // ldc_pin_override

// ===== hdl/ldc_pkg.sv
// Purpose: Shared constants and types for the ladder converter control block.
// Assumes: 8-bit registers on a plain strobe port, byte offsets as printed.
// Notes:   Reset values and field positions are collected here.
package ldc_pkg;
  localparam logic [11:0] LDC_CTRL_OFS       = 12'hf33;
  localparam logic [11:0] LDC_CODE_OFS       = 12'hf34;
  localparam logic [11:0] LDC_GAIN_OFS       = 12'hf31;
  localparam int          LDC_EN_BIT         = 7;
  localparam int          LDC_PINA_BIT       = 5;
  localparam int          LDC_PINB_BIT       = 4;
  localparam int          LDC_HSS_LSB        = 2;
  localparam int          LDC_LSS_BIT        = 0;
  localparam int          LDC_GAIN_LSB       = 2;
  localparam int          LDC_CODE_W         = 5;
  localparam int          LDC_LEVELS         = 32;
  localparam logic [7:0]  LDC_CTRL_MASK      = 8'hbd;
  localparam logic [7:0]  LDC_CODE_MASK      = 8'h1f;
  localparam logic [7:0]  LDC_GAIN_MASK      = 8'h0c;
  localparam logic [7:0]  LDC_CTRL_RST       = 8'h00;
  localparam logic [7:0]  LDC_CODE_RST       = 8'h00;
  localparam logic [7:0]  LDC_GAIN_RST       = 8'h00;

  typedef enum logic [1:0] {
    LDC_HI_SUPPLY,
    LDC_HI_EXT_PIN,
    LDC_HI_FIXED_REF,
    LDC_HI_RESERVED
  } ldc_hi_src_t;

  typedef enum logic [1:0] {
    LDC_GAIN_OFF,
    LDC_GAIN_X1,
    LDC_GAIN_X2,
    LDC_GAIN_X4
  } ldc_gain_t;
endpackage

// ===== hdl/ldc_steer.sv
// Purpose: Decodes the ladder end selects and the fixed reference gain.
// Assumes: Analog switches are one-hot controls, high closes a switch.
// Notes:   A reserved high-end select opens all high-end switches.
`timescale 1ns/1ps
module ldc_steer
  import ldc_pkg::*;
(
  // Settings
  ldc_cfg_if.consumer cfg,
  // Ladder end switches
  output logic        hiSupplySw,
  output logic        hiExtPinSw,
  output logic        hiFixedRefSw,
  output logic        loExtPinSw,
  output logic        loGroundSw,
  // Fixed reference buffer
  output logic        refBufOn,
  output logic [2:0]  refBufGainSel
);
  always_comb begin
    hiSupplySw   = 1'b0;
    hiExtPinSw   = 1'b0;
    hiFixedRefSw = 1'b0;
    if (cfg.enable) begin
      unique case (cfg.highSrc)
        LDC_HI_SUPPLY:    hiSupplySw   = 1'b1;
        LDC_HI_EXT_PIN:   hiExtPinSw   = 1'b1;
        LDC_HI_FIXED_REF: hiFixedRefSw = 1'b1;
        LDC_HI_RESERVED:  hiSupplySw   = 1'b0;
      endcase
    end
  end

  assign loExtPinSw = cfg.enable & cfg.lowSrc;
  assign loGroundSw = cfg.enable & ~cfg.lowSrc;

  always_comb begin
    refBufOn      = 1'b1;
    refBufGainSel = 3'h0;
    unique case (cfg.gain)
      LDC_GAIN_OFF: refBufOn      = 1'b0;
      LDC_GAIN_X1:  refBufGainSel = 3'h1;
      LDC_GAIN_X2:  refBufGainSel = 3'h2;
      LDC_GAIN_X4:  refBufGainSel = 3'h4;
    endcase
  end
endmodule // ldc_steer

// ===== hdl/ldc_top.sv
// Purpose: Register file and control of the 5-bit ladder reference converter.
// Assumes: 50 MHz ref_clk, asynchronous active-low reset, pins sampled here.
// Notes:   The analog ladder is outside; this block drives its switches.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ldc_top
  import ldc_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [11:0]           regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrStb,
  input  wire logic                  regRdStb,
  output logic      [7:0]            regRdData,
  // Power state
  input  wire logic                  sleepActive,
  // Pin a and b port logic requests
  input  wire logic [1:0]            portDriveEn,
  input  wire logic [1:0]            portPullUpEn,
  input  wire logic [1:0]            pinLevel,
  // Pin pad controls
  output logic      [1:0]            padDriveEn,
  output logic      [1:0]            padPullUpEn,
  output logic      [1:0]            padInputEn,
  output logic      [1:0]            pinReadData,
  output logic      [1:0]            padAnalogConnect,
  // Ladder controls
  output logic                       ladderOn,
  output logic      [LDC_LEVELS-1:0] ladderTapSel,
  output logic                       hiSupplySw,
  output logic                       hiExtPinSw,
  output logic                       hiFixedRefSw,
  output logic                       loExtPinSw,
  output logic                       loGroundSw,
  output logic                       refBufOn,
  output logic      [2:0]            refBufGainSel,
  // Ladder voltage consumers
  output logic                       cmpPosFromLadder,
  output logic                       adcChanLadderValid
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] ctrl_ff;
  logic [7:0] code_ff;
  logic [7:0] gain_ff;
  logic [7:0] nxt_rdData;
  logic [1:0] pinMeta_ff;
  logic [1:0] pinSyncA_ff;
  logic [1:0] pinSyncB_ff;
  logic [1:0] pinStable_ff;
  logic       wrCtrl;
  logic       wrCode;
  logic       wrGain;

  assign wrCtrl = regWrStb && (regAddr == LDC_CTRL_OFS);
  assign wrCode = regWrStb && (regAddr == LDC_CODE_OFS);
  assign wrGain = regWrStb && (regAddr == LDC_GAIN_OFS);

  // Sleep has no path into the control register, so wake changes nothing.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= LDC_CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_ff <= regWrData & LDC_CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_ff <= LDC_CODE_RST;
    end else if (wrCode) begin
      code_ff <= regWrData & LDC_CODE_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_ff <= LDC_GAIN_RST;
    end else if (wrGain) begin
      gain_ff <= regWrData & LDC_GAIN_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    nxt_rdData = 8'h00;
    unique case (regAddr)
      LDC_CTRL_OFS: nxt_rdData = ctrl_ff;
      LDC_CODE_OFS: nxt_rdData = code_ff;
      LDC_GAIN_OFS: nxt_rdData = gain_ff;
      default:      nxt_rdData = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      regRdData <= nxt_rdData;
    end else begin
      regRdData <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_ff   <= 2'h0;
      pinSyncA_ff  <= 2'h0;
      pinSyncB_ff  <= 2'h0;
      pinStable_ff <= 2'h0;
    end else begin
      pinMeta_ff  <= pinLevel;
      pinSyncA_ff <= pinMeta_ff;
      pinSyncB_ff <= pinSyncA_ff;
      for (int i = 0; i < 2; i++) begin
        if (pinSyncA_ff[i] == pinSyncB_ff[i]) begin
          pinStable_ff[i] <= pinSyncB_ff[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded settings

  ldc_cfg_if cfg ();

  assign cfg.enable    = ctrl_ff[LDC_EN_BIT];
  assign cfg.pinAOn    = ctrl_ff[LDC_PINA_BIT];
  assign cfg.pinBOn    = ctrl_ff[LDC_PINB_BIT];
  assign cfg.highSrc   = ldc_hi_src_t'(ctrl_ff[LDC_HSS_LSB+:2]);
  assign cfg.lowSrc    = ctrl_ff[LDC_LSS_BIT];
  assign cfg.levelCode = code_ff[LDC_CODE_W-1:0];
  assign cfg.gain      = ldc_gain_t'(gain_ff[LDC_GAIN_LSB+:2]);

  assign ladderOn = cfg.enable;

  // One-hot tap select; all taps open while the ladder is off to save current.
  genvar t;
  generate
    for (t = 0; t < LDC_LEVELS; t++) begin : gTap
      assign ladderTapSel[t] = cfg.enable && (cfg.levelCode == LDC_CODE_W'(t));
    end
  endgenerate

  // The ladder voltage is usable by the comparator and the converter channel.
  assign cmpPosFromLadder   = cfg.enable;
  assign adcChanLadderValid = cfg.enable;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  ldc_pin_override uPins (
    .cfg              (cfg),
    .portDriveEn      (portDriveEn),
    .portPullUpEn     (portPullUpEn),
    .pinLevelSync     (pinStable_ff),
    .padDriveEn       (padDriveEn),
    .padPullUpEn      (padPullUpEn),
    .padInputEn       (padInputEn),
    .pinReadData      (pinReadData),
    .padAnalogConnect (padAnalogConnect)
  );

  ldc_steer uSteer (
    .cfg           (cfg),
    .hiSupplySw    (hiSupplySw),
    .hiExtPinSw    (hiExtPinSw),
    .hiFixedRefSw  (hiFixedRefSw),
    .loExtPinSw    (loExtPinSw),
    .loGroundSw    (loGroundSw),
    .refBufOn      (refBufOn),
    .refBufGainSel (refBufGainSel)
  );

  // sleepActive is accepted but deliberately unused: nothing is cleared on sleep.
  logic unusedSleep;
  assign unusedSleep = sleepActive;
endmodule // ldc_top

// ===== tb/ldc_top_chk.sv
// Purpose: Port-level assertions for the ladder converter control block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Attached to every ldc_top by the bind at the foot.
`timescale 1ns/1ps
module ldc_top_chk
  import ldc_pkg::*;
(
  // Clock, reset and register port
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic [11:0]           regAddr,
  input wire logic [7:0]            regWrData,
  input wire logic                  regWrStb,
  input wire logic                  regRdStb,
  input wire logic [7:0]            regRdData,
  // Pins and ladder
  input wire logic [1:0]            portDriveEn,
  input wire logic [1:0]            padDriveEn,
  input wire logic [1:0]            padPullUpEn,
  input wire logic [1:0]            padInputEn,
  input wire logic [1:0]            pinReadData,
  input wire logic [1:0]            padAnalogConnect,
  input wire logic                  ladderOn,
  input wire logic [LDC_LEVELS-1:0] ladderTapSel,
  input wire logic                  hiSupplySw,
  input wire logic                  hiExtPinSw,
  input wire logic                  hiFixedRefSw,
  input wire logic                  loExtPinSw,
  input wire logic                  loGroundSw,
  input wire logic                  refBufOn,
  input wire logic [2:0]            refBufGainSel,
  input wire logic                  cmpPosFromLadder
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  a_ctrl_readback: assert property (regWrStb && regAddr == LDC_CTRL_OFS ##1
    regRdStb && regAddr == LDC_CTRL_OFS |=> regRdData == ($past(regWrData, 2) & LDC_CTRL_MASK))
    else $error("control read back wrong");
  a_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  a_tap_onehot: assert property (ladderOn ? $onehot(ladderTapSel)
    : ladderTapSel == '0) else $error("tap select wrong");
  a_pin_gate: assert property (padDriveEn == (portDriveEn & padInputEn)
    && ((pinReadData | padPullUpEn) & ~padInputEn) == 2'h0) else $error("pin not overridden");
  a_analog_gate: assert property (padAnalogConnect == (~padInputEn & {2{ladderOn}}))
    else $error("analog connect wrong");
  a_ends_off: assert property (!ladderOn |-> !(hiSupplySw || hiExtPinSw
    || hiFixedRefSw || loExtPinSw || loGroundSw)) else $error("switch closed while off");
  a_hi_onehot: assert property ($onehot0({hiSupplySw, hiExtPinSw, hiFixedRefSw}))
    else $error("two high switches");
  a_lo_select: assert property (ladderOn |-> loExtPinSw ^ loGroundSw)
    else $error("low end select wrong");
  a_cmp_follow: assert property (cmpPosFromLadder == ladderOn)
    else $error("comparator feed wrong");
  a_gain_code: assert property (refBufOn == (refBufGainSel != 3'h0)
    && $onehot0(refBufGainSel)) else $error("gain select wrong");
  a_ctrl_hold: assert property ($changed(ladderOn) |->
    $past(regWrStb && regAddr == LDC_CTRL_OFS)) else $error("enable moved without write");
endmodule // ldc_top_chk

bind ldc_top ldc_top_chk u_chk (.*);

// ===== tb/testbench.sv
// Purpose: Directed register-sequence tests of the ladder control block.
// Assumes: 50 MHz clock, five reset cycles at start.
// Notes:   Expected values are written out by hand from the bit layouts.
`timescale 1ns/1ps
module testbench;
  import ldc_pkg::*;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b1;
  logic [11:0]           regAddr = 12'h000;
  logic [7:0]            regWrData = 8'h00;
  logic                  regWrStb = 1'b0;
  logic                  regRdStb = 1'b0;
  logic                  sleepActive = 1'b0;
  logic [1:0]            portDriveEn = 2'h0;
  logic [1:0]            portPullUpEn = 2'h0;
  logic [1:0]            pinLevel = 2'h0;
  logic [7:0]            regRdData;
  logic [1:0]            padDriveEn, padPullUpEn, padInputEn, pinReadData, padAnalogConnect;
  logic [LDC_LEVELS-1:0] ladderTapSel;
  logic                  ladderOn, hiSupplySw, hiExtPinSw, hiFixedRefSw, loExtPinSw;
  logic                  loGroundSw, refBufOn, cmpPosFromLadder, adcChanLadderValid;
  logic [2:0]            refBufGainSel;
  logic [7:0]            pinCtrl [4] = '{8'ha0, 8'h90, 8'h30, 8'h00};
  logic [11:0]           pinExp [4] = '{12'haa7, 12'h55b, 12'h000, 12'hff0};
  int                    failures = 0;
  int                    compares = 0;

  ldc_top DUT (.*);

  always #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    #1;
  endtask

  // Write then read with no gap, so back-to-back strobes are exercised too.
  task automatic wrrd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData, e, "read");
  endtask

  // Read only, so reset and sleep values are seen without a write in front.
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData, e, "read");
  endtask

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    test_done();
  end

  initial begin
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk({ladderOn, padAnalogConnect, padInputEn}, 5'h03, "reset pins");
    rd(LDC_CTRL_OFS, 8'h00);
    wrrd(12'hf35, 8'hff, 8'h00);
    rd(LDC_CODE_OFS, 8'h00);
    wrrd(LDC_CTRL_OFS, 8'hff, 8'hbd);
    wrrd(LDC_CODE_OFS, 8'hff, 8'h1f);
    wrrd(LDC_GAIN_OFS, 8'hff, 8'h0c);
    $display("test registers done");
    wr(LDC_CTRL_OFS, 8'h80);
    for (int c = 0; c < 32; c++) begin
      wr(LDC_CODE_OFS, 8'(c));
      chk(ladderTapSel, 32'h1 << c, "tap");
    end
    $display("test taps done");
    for (int p = 0; p < 8; p++) begin
      wr(LDC_CTRL_OFS, 8'(128 + p[2:1] * 4 + p[0]));
      chk({hiSupplySw, hiExtPinSw, hiFixedRefSw},
          p[2:1] == 3 ? 0 : 3'h4 >> p[2:1], "hi");
      chk({loExtPinSw, loGroundSw}, p[0] ? 2'h2 : 2'h1, "lo");
    end
    $display("test sources done");
    @(posedge ref_clk);
    portDriveEn <= 2'h3;
    portPullUpEn <= 2'h3;
    pinLevel <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      wr(LDC_CTRL_OFS, pinCtrl[i]);
      repeat (6) @(posedge ref_clk);
      #1;
      chk({padDriveEn, padPullUpEn, padInputEn, pinReadData, padAnalogConnect,
           cmpPosFromLadder, adcChanLadderValid}, pinExp[i], "pins");
    end
    chk(ladderTapSel, 32'h0, "tap off");
    $display("test pins done");
    for (int g = 0; g < 4; g++) begin
      wr(LDC_GAIN_OFS, 8'(g * 4));
      chk({refBufOn, refBufGainSel},
          g == 0 ? 4'h0 : 4'h8 | 4'(1 << (g - 1)), "gain");
    end
    $display("test gain done");
    // Software switches the ladder off before sleep; the settings must survive.
    wr(LDC_CTRL_OFS, 8'h35);
    sleepActive <= 1'b1;
    repeat (10) @(posedge ref_clk);
    sleepActive <= 1'b0;
    rd(LDC_CTRL_OFS, 8'h35);
    wrrd(12'hf36, 8'h00, 8'h00);
    wrrd(LDC_CTRL_OFS + 12'h001, 8'h1f, 8'h1f);
    @(posedge ref_clk);
    wrrd(LDC_CTRL_OFS, 8'hb5, 8'hb5);
    rst_n <= 1'b0;
    #1;
    chk({ladderOn, padAnalogConnect}, 3'h0, "reset off");
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(LDC_CTRL_OFS, 8'h00);
    rd(LDC_CODE_OFS, 8'h00);
    wrrd(12'hf35, 8'h00, 8'h00);
    rd(LDC_GAIN_OFS, 8'h00);
    $display("test sleep and reset done");
    test_done();
  end
endmodule // testbench
